// File: verilog/dlfmc_pkg.sv
package dlfmc_pkg;
  // How it works
  // - Flash gives each leg 128 levels, 10.9 mA up to 1500 mA.
  // - Flash start steps leg level up one code at a time to target.
  // - A config bit makes leg two copy the leg one settings.
  // - Flash started by mode field clears mode bits at timeout.
  // - Torch gives 128 levels, 0.977 mA to 179 mA, from torch settings.
  // - Torch starts on mode 10 or on enabled torch pin in torch use.
  // - Torch steps up one level at a time to target at the timing register rate.
  // - Torch ignores flash timeout and the sync input.
  // - IR target of each leg is its flash brightness.
  // - Mode 01 enters IR with converter on in pass mode.
  // - In IR the strobe level switches enabled legs; host owns timing.
  // - In IR leg current jumps between off and target, no ramp.
  // - Chip enable pin low resets state and all registers.
  // - Strobe pin triggers flash; sync input curtails flash current.
  // - After reset the torch/thermistor pin is in torch use, but its enable bit (bit 4) is off.
  // - With enough input headroom the converter holds pass mode.
  // - Readable flags: timeout, LED hot, LED open/short, die hot, sync, UV.
  // - Switching frequency selectable between 2 MHz and 4 MHz.
  // - Sync high in flash drops to torch level; low restores flash.
  // - Fault sets flag, clears mode, standby until flags are read.

  localparam int CLK_HZ       = 40_000_000;
  localparam int MS_PER_S     = 1000;
  localparam int TO_MIN_MS    = 10;
  localparam int TO_STEP_MS   = 26;
  localparam int TO_MIN_CYC   = TO_MIN_MS * (CLK_HZ / MS_PER_S);
  localparam int TO_STEP_CYC  = TO_STEP_MS * (CLK_HZ / MS_PER_S);
  localparam int FLASH_STEP_CYC  = 4;
  localparam int TORCH_STEP_BASE = 64;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int LVL_W  = 7;
  localparam logic [LVL_W-1:0] LVL_ZERO = 7'h00;

  localparam logic [ADDR_W-1:0] ADDR_ENABLE = 6'h00;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 6'h04;
  localparam logic [ADDR_W-1:0] ADDR_FL1    = 6'h08;
  localparam logic [ADDR_W-1:0] ADDR_FL2    = 6'h0c;
  localparam logic [ADDR_W-1:0] ADDR_TB1    = 6'h10;
  localparam logic [ADDR_W-1:0] ADDR_TB2    = 6'h14;
  localparam logic [ADDR_W-1:0] ADDR_TIMING = 6'h18;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS  = 6'h1c;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 6'h20;

  // Enable register fields
  localparam int EN_LEG1      = 2;
  localparam int EN_TORCH_PIN = 4;
  localparam int EN_STROBE    = 5;
  localparam int EN_SYNC      = 6;
  // Config register fields
  localparam int CFG_PIN_TEMP = 0;
  localparam int CFG_FREQ_4M  = 1;
  localparam int CFG_MATCH    = 2;
  // Timing register fields
  localparam int TIM_TO_LSB   = 0;
  localparam int TIM_RAMP_LSB = 4;
  // Flag bits
  localparam int FLG_TIMEOUT  = 0;
  localparam int FLG_LED_HOT  = 1;
  localparam int FLG_LED_BAD  = 2;
  localparam int FLG_DIE_HOT  = 3;
  localparam int FLG_SYNC     = 4;
  localparam int FLG_UVLO     = 5;
  localparam int FLG_N        = 6;
  localparam logic [FLG_N-1:0] FLG_FAULTS = 6'h2e;

  localparam logic [7:0] ENABLE_RST = 8'h0c;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] BRIGHT_RST = 8'h3f;
  localparam logic [7:0] TIMING_RST = 8'h1a;

  typedef enum logic [1:0] {
    op_standby = 2'b00,
    op_ir      = 2'b01,
    op_torch   = 2'b10,
    op_flash   = 2'b11
  } dlfmc_op_type;

  typedef struct packed {
    logic strobe;
    logic pa_sync;
    logic torch_pin;
    logic headroom_ok;
    logic led_hot;
    logic led_bad;
    logic die_hot;
    logic uvlo;
  } dlfmc_pins_type;
  localparam int PIN_N = $bits(dlfmc_pins_type);

  typedef struct packed {
    logic             on;
    logic             flash_range;
    logic [LVL_W-1:0] level;
  } dlfmc_leg_type;
endpackage : dlfmc_pkg

// File: verilog/dlfmc_top.sv
`timescale 1ns/1ps
module dlfmc_top
  import dlfmc_pkg::*;
#(
  parameter int TO_MIN_CYCLES  = TO_MIN_CYC,
  parameter int TO_STEP_CYCLES = TO_STEP_CYC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Device pins
  input  wire logic              chip_enable_pin,
  input  wire dlfmc_pins_type    pins,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  output logic      [DATA_W-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  // Current legs and converter
  output dlfmc_leg_type          leg_one_source,
  output dlfmc_leg_type          leg_two_source,
  output logic                   boost_on,
  output logic                   pass_mode,
  output logic                   freq_4m
);

  logic [PIN_N-1:0]  pin_s1_ff;
  logic [PIN_N-1:0]  pin_s2_ff;
  logic              en_s1_ff;
  logic              en_s2_ff;
  logic              dev_rst_ff;
  dlfmc_pins_type    ps;
  logic              wait_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic              req;
  logic              acc_wr;
  logic              acc_rd;
  logic [7:0]        en_ff;
  logic [7:0]        cfg_ff;
  logic [7:0]        fl1_ff;
  logic [7:0]        fl2_ff;
  logic [7:0]        tb1_ff;
  logic [7:0]        tb2_ff;
  logic [7:0]        tim_ff;
  logic [FLG_N-1:0]  flag_ff;
  logic [FLG_N-1:0]  flag_set;
  logic [FLG_N-1:0]  flag_clr;
  logic              fault_now;
  logic              lockout;
  dlfmc_op_type      op_ff;
  dlfmc_op_type      nxt_op;
  logic              fl_reg_ff;
  logic              strobe_done_ff;
  logic              strobe_fl;
  logic              torch_pin_on;
  logic [31:0]       to_cnt_ff;
  logic [31:0]       to_lim;
  logic              to_expire;
  logic              sync_act;
  logic              sync_prev_ff;
  logic [15:0]       step_ff;
  logic [15:0]       step_per;
  logic              tick;
  logic [LVL_W-1:0]  ramp_ff [2];
  logic [LVL_W-1:0]  fl_lvl  [2];
  logic [LVL_W-1:0]  tb_lvl  [2];
  dlfmc_leg_type     leg_ff  [2];
  logic              pass_ff;
  logic              boost_ff;
  logic              freq_ff;

  // Pin synchronisers
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (rst) begin
          pin_s1_ff[gi] <= 1'b0;
          pin_s2_ff[gi] <= 1'b0;
        end else begin
          pin_s1_ff[gi] <= pins[gi];
          pin_s2_ff[gi] <= pin_s1_ff[gi];
        end
      end
    end
  endgenerate
  assign ps = dlfmc_pins_type'(pin_s2_ff);

  always_ff @(posedge clk) begin
    if (rst) begin
      en_s1_ff <= 1'b0;
      en_s2_ff <= 1'b0;
    end else begin
      en_s1_ff <= chip_enable_pin;
      en_s2_ff <= en_s1_ff;
    end
  end

  // Device reset from chip enable pin
  always_ff @(posedge clk) begin
    if (rst) begin
      dev_rst_ff <= 1'b1;
    end else begin
      dev_rst_ff <= !en_s2_ff;
    end
  end

  // Bus slave: one wait cycle per access
  assign req    = avs_read || avs_write;
  assign acc_wr = avs_write && !wait_ff;
  assign acc_rd = avs_read && !wait_ff;

  always_ff @(posedge clk) begin
    if (dev_rst_ff) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= !(req && wait_ff);
    end
  end

  always_comb begin
    nxt_rdata = '0;
    case (avs_address)
      ADDR_ENABLE: nxt_rdata[7:0] = en_ff;
      ADDR_CONFIG: nxt_rdata[7:0] = cfg_ff;
      ADDR_FL1:    nxt_rdata[7:0] = fl1_ff;
      ADDR_FL2:    nxt_rdata[7:0] = fl2_ff;
      ADDR_TB1:    nxt_rdata[7:0] = tb1_ff;
      ADDR_TB2:    nxt_rdata[7:0] = tb2_ff;
      ADDR_TIMING: nxt_rdata[7:0] = tim_ff;
      ADDR_FLAGS:  nxt_rdata[FLG_N-1:0] = flag_ff;
      ADDR_STATUS: nxt_rdata = {9'h000, ramp_ff[1], 1'b0, ramp_ff[0],
                                3'h0, lockout, boost_ff, pass_ff, op_ff};
      default:     nxt_rdata = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (dev_rst_ff) begin
      rdata_ff <= '0;
    end else if (avs_read && wait_ff) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Enable register; hardware clears mode bits
  always_ff @(posedge clk) begin
    if (dev_rst_ff) begin
      en_ff <= ENABLE_RST;
    end else begin
      if (acc_wr && avs_address == ADDR_ENABLE) begin
        en_ff <= avs_writedata[7:0];
      end
      if (fault_now || (to_expire && fl_reg_ff)) begin
        en_ff[1:0] <= op_standby;
      end
    end
  end

  // Plain software registers
  always_ff @(posedge clk) begin
    if (dev_rst_ff) begin
      cfg_ff <= CONFIG_RST;
      fl1_ff <= BRIGHT_RST;
      fl2_ff <= BRIGHT_RST;
      tb1_ff <= BRIGHT_RST;
      tb2_ff <= BRIGHT_RST;
      tim_ff <= TIMING_RST;
    end else if (acc_wr) begin
      case (avs_address)
        ADDR_CONFIG: cfg_ff <= avs_writedata[7:0];
        ADDR_FL1:    fl1_ff <= avs_writedata[7:0];
        ADDR_FL2:    fl2_ff <= avs_writedata[7:0];
        ADDR_TB1:    tb1_ff <= avs_writedata[7:0];
        ADDR_TB2:    tb2_ff <= avs_writedata[7:0];
        ADDR_TIMING: tim_ff <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  // Flags: set wins over clear-on-read
  assign fault_now = ps.led_hot || ps.led_bad || ps.die_hot || ps.uvlo;
  assign sync_act  = op_ff == op_flash && en_ff[EN_SYNC] && ps.pa_sync;
  always_comb begin
    flag_set              = '0;
    flag_set[FLG_TIMEOUT] = to_expire;
    flag_set[FLG_LED_HOT] = ps.led_hot;
    flag_set[FLG_LED_BAD] = ps.led_bad;
    flag_set[FLG_DIE_HOT] = ps.die_hot;
    flag_set[FLG_SYNC]    = sync_act && !sync_prev_ff;
    flag_set[FLG_UVLO]    = ps.uvlo;
  end
  assign flag_clr = (acc_rd && avs_address == ADDR_FLAGS) ? '1 : '0;

  always_ff @(posedge clk) begin
    if (dev_rst_ff) begin
      flag_ff      <= '0;
      sync_prev_ff <= 1'b0;
    end else begin
      flag_ff      <= (flag_ff & ~flag_clr) | flag_set;
      sync_prev_ff <= sync_act;
    end
  end
  assign lockout = |(flag_ff & FLG_FAULTS);

  // Operating state selection
  assign torch_pin_on = en_ff[EN_TORCH_PIN] && !cfg_ff[CFG_PIN_TEMP]
                        && ps.torch_pin;
  assign strobe_fl    = en_ff[EN_STROBE] && ps.strobe
                        && !strobe_done_ff;

  always_comb begin
    if (lockout || fault_now || to_expire) begin
      nxt_op = op_standby;
    end else begin
      unique case (en_ff[1:0])
        2'b11: nxt_op = op_flash;
        2'b01: nxt_op = op_ir;
        2'b10: nxt_op = op_torch;
        2'b00: begin
          if (strobe_fl) begin
            nxt_op = op_flash;
          end else if (torch_pin_on) begin
            nxt_op = op_torch;
          end else begin
            nxt_op = op_standby;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (dev_rst_ff) begin
      op_ff     <= op_standby;
      fl_reg_ff <= 1'b0;
    end else begin
      op_ff     <= nxt_op;
      fl_reg_ff <= nxt_op == op_flash && en_ff[1:0] == op_flash;
    end
  end

  // Strobe flash must see strobe low before it can fire again
  always_ff @(posedge clk) begin
    if (dev_rst_ff) begin
      strobe_done_ff <= 1'b0;
    end else if (!ps.strobe) begin
      strobe_done_ff <= 1'b0;
    end else if (to_expire && !fl_reg_ff) begin
      strobe_done_ff <= 1'b1;
    end
  end

  // Flash timeout, only counted in flash
  assign to_lim = 32'(TO_MIN_CYCLES)
                + 32'(tim_ff[TIM_TO_LSB +: 4]) * 32'(TO_STEP_CYCLES);
  assign to_expire = op_ff == op_flash && to_cnt_ff == to_lim - 32'd1;

  always_ff @(posedge clk) begin
    if (dev_rst_ff || op_ff != op_flash || nxt_op != op_flash) begin
      to_cnt_ff <= '0;
    end else begin
      to_cnt_ff <= to_cnt_ff + 32'd1;
    end
  end

  // Ramp step timer
  assign step_per = (op_ff == op_torch)
                  ? 16'(TORCH_STEP_BASE) << tim_ff[TIM_RAMP_LSB +: 3]
                  : 16'(FLASH_STEP_CYC);
  assign tick     = step_ff == 16'h0000;

  always_ff @(posedge clk) begin
    if (dev_rst_ff || op_ff == op_standby) begin
      step_ff <= '0;
    end else if (tick) begin
      step_ff <= step_per - 16'd1;
    end else begin
      step_ff <= step_ff - 16'd1;
    end
  end

  // Per-leg targets; matching copies leg one
  assign fl_lvl[0] = fl1_ff[LVL_W-1:0];
  assign tb_lvl[0] = tb1_ff[LVL_W-1:0];
  assign fl_lvl[1] = cfg_ff[CFG_MATCH] ? fl1_ff[LVL_W-1:0]
                                       : fl2_ff[LVL_W-1:0];
  assign tb_lvl[1] = cfg_ff[CFG_MATCH] ? tb1_ff[LVL_W-1:0]
                                       : tb2_ff[LVL_W-1:0];

  generate
    for (gi = 0; gi < 2; gi++) begin : g_leg
      logic [LVL_W-1:0] tgt;
      assign tgt = (op_ff == op_torch) ? tb_lvl[gi] : fl_lvl[gi];

      // Ramp from the lowest code on each activation
      always_ff @(posedge clk) begin
        if (dev_rst_ff || nxt_op != op_ff) begin
          ramp_ff[gi] <= LVL_ZERO;
        end else if (op_ff == op_torch || op_ff == op_flash) begin
          if (ramp_ff[gi] > tgt) begin
            ramp_ff[gi] <= tgt;
          end else if (tick && ramp_ff[gi] < tgt) begin
            ramp_ff[gi] <= ramp_ff[gi] + 7'd1;
          end
        end
      end

      always_ff @(posedge clk) begin
        if (dev_rst_ff) begin
          leg_ff[gi] <= '0;
        end else begin
          unique case (op_ff)
            op_standby: leg_ff[gi] <= '0;
            op_ir: leg_ff[gi] <= '{on: en_ff[EN_LEG1+gi] && ps.strobe,
                                   flash_range: 1'b1,
                                   level: fl_lvl[gi]};
            op_torch: leg_ff[gi] <= '{on: en_ff[EN_LEG1+gi],
                                      flash_range: 1'b0,
                                      level: ramp_ff[gi]};
            op_flash: begin
              if (sync_act) begin
                leg_ff[gi] <= '{on: en_ff[EN_LEG1+gi],
                                flash_range: 1'b0,
                                level: tb_lvl[gi]};
              end else begin
                leg_ff[gi] <= '{on: en_ff[EN_LEG1+gi],
                                flash_range: 1'b1,
                                level: ramp_ff[gi]};
              end
            end
          endcase
        end
      end
    end
  endgenerate

  // Converter control
  always_ff @(posedge clk) begin
    if (dev_rst_ff) begin
      pass_ff  <= 1'b0;
      boost_ff <= 1'b0;
      freq_ff  <= 1'b0;
    end else begin
      pass_ff  <= op_ff == op_ir
                  || (op_ff != op_standby && ps.headroom_ok);
      boost_ff <= op_ff != op_standby && op_ff != op_ir
                  && !ps.headroom_ok;
      freq_ff  <= cfg_ff[CFG_FREQ_4M];
    end
  end

  assign avs_waitrequest = wait_ff;
  assign avs_readdata    = rdata_ff;
  assign leg_one_source  = leg_ff[0];
  assign leg_two_source  = leg_ff[1];
  assign pass_mode       = pass_ff;
  assign boost_on        = boost_ff;
  assign freq_4m         = freq_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (dev_rst_ff);

  a_flash_ramp_step: assert property (
    op_ff == op_flash && $past(op_ff) == op_flash
    && ramp_ff[0] > $past(ramp_ff[0])
    |-> ramp_ff[0] == $past(ramp_ff[0]) + 7'd1)
    else $error("flash ramp skipped a level");
  a_torch_ramp_gap: assert property (
    op_ff == op_torch && ramp_ff[0] != $past(ramp_ff[0])
    && ramp_ff[0] < tb_lvl[0] && $stable(op_ff)
    |=> !$changed(ramp_ff[0]))
    else $error("torch ramp stepped twice in a row");
  a_match_legs: assert property (
    cfg_ff[CFG_MATCH] && op_ff == op_ir
    |=> leg_two_source.level == leg_one_source.level)
    else $error("matched legs differ");
  a_timeout_mode: assert property (
    to_expire && fl_reg_ff |=> en_ff[1:0] == op_standby)
    else $error("mode bits not cleared at timeout");
  a_torch_no_timeout: assert property (
    op_ff == op_torch |-> to_cnt_ff == 32'd0 && !sync_act)
    else $error("torch saw timeout or sync");
  a_ir_direct: assert property (
    op_ff == op_ir |=> leg_one_source.on
                       == $past(en_ff[EN_LEG1] && ps.strobe))
    else $error("ir leg not following strobe");
  a_ir_no_ramp: assert property (
    op_ff == op_ir |=> leg_one_source.level == $past(fl_lvl[0]))
    else $error("ir level not immediate");
  a_ir_pass: assert property (
    op_ff == op_ir |=> pass_mode && !boost_on)
    else $error("ir not in pass mode");
  a_sync_torch: assert property (
    sync_act |=> !leg_one_source.flash_range
                 && leg_one_source.level == $past(tb_lvl[0]))
    else $error("sync did not drop to torch");
  a_fault_standby: assert property (
    lockout |=> op_ff == op_standby ##1 !leg_one_source.on)
    else $error("fault did not force standby");
  a_timeout_off: assert property (
    to_expire |-> ##2 !leg_one_source.on && !leg_two_source.on)
    else $error("legs on after timeout");
  a_pin_reset: assert property (@(posedge clk) disable iff (rst)
    !en_s2_ff |=> dev_rst_ff)
    else $error("chip enable low did not reset");

  c_flash_timeout: cover property (fl_reg_ff && to_expire);
  c_sync_restore: cover property (sync_act ##1 !sync_act && op_ff == op_flash);
  c_ir_pulse: cover property (op_ff == op_ir && leg_one_source.on);
  c_pin_torch: cover property (torch_pin_on && op_ff == op_torch);

endmodule : dlfmc_top

// File: dv/dlfmc_host_model.sv
`timescale 1ns/1ps
module dlfmc_host_model
  import dlfmc_pkg::*;
(
  // Clock
  input  wire logic           clk,
  // Levels the bench asks for
  input  wire dlfmc_pins_type want,
  // Pins towards the device
  output dlfmc_pins_type      pins
);
  // Pull-downs hold every pin low until driven
  initial pins = '0;

  // Pins change only after an edge; host owns all pulse timing
  always @(posedge clk) begin
    pins <= want;
  end
endmodule : dlfmc_host_model

// File: dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin checks_done++; \
  if ((got) !== (exp)) begin num_errors++; \
  $display("MISMATCH t=%0t %s got %0h exp %0h", $time, msg, got, exp); \
  end end
module tb_top
  import dlfmc_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              chip_enable_pin = 1'b1;
  dlfmc_pins_type    want = '0;
  dlfmc_pins_type    pins;
  logic [ADDR_W-1:0] avs_address = '0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  dlfmc_leg_type     leg_one_source;
  dlfmc_leg_type     leg_two_source;
  dlfmc_leg_type     prev_leg = '0;
  logic              boost_on;
  logic              pass_mode;
  logic              freq_4m;
  logic [DATA_W-1:0] q;
  int                num_errors = 0;
  int                checks_done = 0;
  int                jumps = 0;
  int                first_lvl = 0;
  int                lt, lf;
  int                ra[$] = '{0, 4, 8, 12, 16, 20, 24, 60};
  int                rv[$] = '{12, 0, 63, 63, 63, 63, 26, 0};
  int                fb[$] = '{FLG_LED_HOT, FLG_LED_BAD, FLG_DIE_HOT,
                               FLG_UVLO};
  int                pb[$] = '{3, 2, 1, 0};

  always #12.5 clk = ~clk;

  dlfmc_host_model host (.clk(clk), .want(want), .pins(pins));

  dlfmc_top #(.TO_MIN_CYCLES(20), .TO_STEP_CYCLES(8)) dut (
    .clk(clk), .rst(rst), .chip_enable_pin(chip_enable_pin),
    .pins(pins), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .leg_one_source(leg_one_source), .leg_two_source(leg_two_source),
    .boost_on(boost_on), .pass_mode(pass_mode), .freq_4m(freq_4m));

  // Watches the first leg for skipped ramp codes
  always @(posedge clk) begin
    if (leg_one_source.on && !prev_leg.on)
      first_lvl <= leg_one_source.level;
    if (leg_one_source.on && prev_leg.on &&
        leg_one_source.flash_range == prev_leg.flash_range &&
        leg_one_source.level > prev_leg.level + 1)
      jumps <= jumps + 1;
    prev_leg <= leg_one_source;
  end

  function automatic dlfmc_leg_type leg(input logic fr, input int l);
    return '{1'b1, fr, l[LVL_W-1:0]};
  endfunction : leg

  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= {24'h000000, d};
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic wait_leg(input dlfmc_leg_type e, input int lim);
    for (int n = 0; n < lim && leg_one_source !== e; n++) @(posedge clk);
  endtask : wait_leg

  task automatic wait_off(input int lim);
    for (int n = 0; n < lim && leg_one_source.on !== 1'b0; n++)
      @(posedge clk);
  endtask : wait_off

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    conclude();
  end

  initial begin
    void'($urandom(32'h066e));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    foreach (ra[i]) begin
      bus(1'b0, ra[i][ADDR_W-1:0], 8'h00);
      `CHK(q, rv[i], "reset value")
    end
    `CHK(leg_one_source.on, 1'b0, "idle leg")
    $display("test reset values done");

    // Torch by mode, legs matched, sync high all along
    lt = 2 + $urandom % 8;
    want.headroom_ok <= $urandom % 2;
    bus(1'b1, ADDR_CONFIG, 8'h06);
    bus(1'b1, ADDR_TB1, lt[7:0]);
    bus(1'b1, ADDR_TIMING, 8'h0a);
    want.pa_sync <= 1'b1;
    jumps = 0;
    bus(1'b1, ADDR_ENABLE, 8'h4e);
    wait_leg(leg(1'b0, lt), 64 * 12);
    `CHK(leg_one_source, leg(1'b0, lt), "torch level")
    `CHK(leg_two_source, leg(1'b0, lt), "matched leg")
    `CHK(jumps, 0, "torch ramp")
    `CHK(first_lvl <= 1, 1'b1, "torch ramp start")
    `CHK(freq_4m, 1'b1, "freq select")
    `CHK(pass_mode, want.headroom_ok, "pass by headroom")
    `CHK(boost_on, !want.headroom_ok, "boost by headroom")
    repeat (200) @(posedge clk);
    `CHK(leg_one_source, leg(1'b0, lt), "torch holds")
    bus(1'b1, ADDR_ENABLE, 8'h0c);
    want.pa_sync <= 1'b0;
    wait_off(20);
    $display("test torch done");

    // Flash by mode with sync pulse and timeout
    lf = 3 + $urandom % 5;
    bus(1'b1, ADDR_CONFIG, 8'h00);
    bus(1'b1, ADDR_FL1, lf[7:0]);
    bus(1'b1, ADDR_TIMING, 8'h0f);
    jumps = 0;
    bus(1'b1, ADDR_ENABLE, 8'h47);
    wait_leg(leg(1'b1, lf), 60);
    `CHK(leg_one_source, leg(1'b1, lf), "flash level")
    `CHK(jumps, 0, "flash ramp")
    want.pa_sync <= 1'b1;
    wait_leg(leg(1'b0, lt), 12);
    `CHK(leg_one_source, leg(1'b0, lt), "sync to torch")
    want.pa_sync <= 1'b0;
    wait_leg(leg(1'b1, lf), 40);
    `CHK(leg_one_source, leg(1'b1, lf), "sync restore")
    want.pa_sync <= 1'b1;
    wait_off(160);
    `CHK(leg_one_source.on, 1'b0, "timeout off")
    bus(1'b0, ADDR_ENABLE, 8'h00);
    `CHK(q[1:0], 2'b00, "mode cleared")
    bus(1'b0, ADDR_FLAGS, 8'h00);
    `CHK(q[FLG_TIMEOUT], 1'b1, "timeout flag")
    `CHK(q[FLG_SYNC], 1'b1, "sync flag")
    want.pa_sync <= 1'b0;
    bus(1'b0, ADDR_FLAGS, 8'h00);
    `CHK(q[FLG_N-1:0], 6'h00, "flags cleared")
    $display("test flash done");

    // IR pulses from the strobe level, legs matched
    bus(1'b1, ADDR_CONFIG, 8'h04);
    bus(1'b1, ADDR_ENABLE, 8'h25);
    repeat (6) @(posedge clk);
    `CHK(pass_mode, 1'b1, "ir pass")
    repeat (3) begin
      want.strobe <= 1'b1;
      wait_leg(leg(1'b1, lf), 10);
      `CHK(leg_one_source, leg(1'b1, lf), "ir on")
      @(posedge clk);
      `CHK(first_lvl, lf, "ir no ramp")
      repeat ($urandom % 20) @(posedge clk);
      want.strobe <= 1'b0;
      wait_off(10);
      `CHK(leg_one_source.on, 1'b0, "ir off")
    end
    $display("test ir done");

    // Strobe flash from standby
    bus(1'b1, ADDR_ENABLE, 8'h24);
    want.strobe <= 1'b1;
    wait_leg(leg(1'b1, lf), 60);
    `CHK(leg_one_source, leg(1'b1, lf), "strobe flash")
    wait_off(200);
    `CHK(leg_one_source.on, 1'b0, "strobe timeout")
    want.strobe <= 1'b0;
    bus(1'b0, ADDR_FLAGS, 8'h00);
    $display("test strobe done");

    // Torch from the torch pin
    bus(1'b1, ADDR_CONFIG, 8'h01);
    bus(1'b1, ADDR_ENABLE, 8'h14);
    want.torch_pin <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK(leg_one_source.on, 1'b0, "thermistor pin no torch")
    bus(1'b1, ADDR_CONFIG, 8'h00);
    wait_leg(leg(1'b0, lt), 64 * 12);
    `CHK(leg_one_source, leg(1'b0, lt), "pin torch")
    want.torch_pin <= 1'b0;
    wait_off(20);
    $display("test torch pin done");

    // Each fault drops torch and latches its flag
    foreach (fb[i]) begin
      bus(1'b1, ADDR_ENABLE, 8'h0e);
      wait_leg(leg(1'b0, lt), 64 * 12);
      want[pb[i]] <= 1'b1;
      wait_off(20);
      `CHK(leg_one_source.on, 1'b0, "fault off")
      want[pb[i]] <= 1'b0;
      bus(1'b0, ADDR_ENABLE, 8'h00);
      `CHK(q[1:0], 2'b00, "fault mode")
      bus(1'b0, ADDR_FLAGS, 8'h00);
      `CHK(q[fb[i]], 1'b1, "fault flag")
    end
    $display("test faults done");

    // Enable pin low restores registers
    bus(1'b1, ADDR_TB1, 8'h05);
    chip_enable_pin <= 1'b0;
    repeat (5) @(posedge clk);
    chip_enable_pin <= 1'b1;
    repeat (8) @(posedge clk);
    bus(1'b0, ADDR_TB1, 8'h00);
    `CHK(q, 32'h0000003f, "enable pin reset")
    $display("test chip enable done");
    conclude();
  end
endmodule : tb_top
